// ==== rtl/can_timing_pkg.sv ====
// Purpose: shared constants for the can bit timing, filter and routing block
// Assumes: 16-bit register port, word index addressing
// Notes:   register indices are local choices
package can_timing_pkg;
  localparam int unsigned AW = 4;
  localparam int unsigned DW = 16;
  localparam logic [AW-1:0] ADDR_ERR_CNT   = 4'h0;
  localparam logic [AW-1:0] ADDR_CFG_ONE   = 4'h1;
  localparam logic [AW-1:0] ADDR_CFG_TWO   = 4'h2;
  localparam logic [AW-1:0] ADDR_FLT_EN    = 4'h3;
  localparam logic [AW-1:0] ADDR_ROUTE0    = 4'h4;
  localparam logic [AW-1:0] ADDR_ERR_EVT   = 4'h8;
  localparam logic [DW-1:0] CFG_ONE_MASK   = 16'h00FF;
  localparam logic [DW-1:0] CFG_TWO_MASK   = 16'h47FF;
  localparam logic [DW-1:0] FLT_EN_RESET   = 16'h003F;
  localparam int unsigned JUMP_LSB = 6;
  localparam int unsigned PRESC_LSB = 0;
  localparam int unsigned WAK_BIT = 14;
  localparam int unsigned PH2_LSB = 8;
  localparam int unsigned PH2TS_BIT = 7;
  localparam int unsigned TRIPLE_BIT = 6;
  localparam int unsigned PH1_LSB = 3;
  localparam int unsigned PRS_LSB = 0;
  localparam logic [3:0] PROC_QUANTA = 4'h2;
  localparam logic [3:0] DEST_FIFO = 4'hF;
  localparam logic [8:0] TEC_PASSIVE = 9'h080;
  localparam logic [8:0] TEC_BUSOFF = 9'h100;
  localparam logic [7:0] TX_ERR_INC = 8'h08;
  localparam logic [7:0] RX_ERR_INC = 8'h01;
  localparam logic [7:0] RX_HALF = 8'h7F;
  localparam logic [7:0] RX_RESTART = 8'h77;
endpackage

// ==== rtl/can_timing_core.sv ====
// Purpose: register file, bit timing engine, fault tallies and filter routing
// Assumes: can_rx_i synchronous to mclk_i; fault events are one-cycle pulses
// Notes:   resync on recessive-to-dominant edge inside the jump window, only when it falls in a quantum tick clock; no hard sync
`timescale 1ns/10ps
module can_timing_core
  import can_timing_pkg::*;
#(
  parameter int unsigned NFLT = 16
)(
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [DW-1:0] rdata_o,
  input  wire logic          can_rx_i,
  input  wire logic [3:0]    hit_num_i,
  input  wire logic          hit_i,
  output logic               route_valid_o,
  output logic [3:0]         route_buf_o,
  output logic               route_fifo_o,
  output logic               sample_o,
  output logic               sample_pt_o,
  output logic               wake_o
);
  // ***************************************************************
  // register file
  // ***************************************************************
  logic [DW-1:0] cfg_one_reg;
  logic [DW-1:0] cfg_two_reg;
  logic [DW-1:0] flt_en_reg;
  logic [DW-1:0] route_reg [4];
  logic [8:0]    tec_reg;
  logic [7:0]    rec_reg;
  logic [DW-1:0] rdata_next;
  logic [DW-1:0] err_word;
  logic          wr_cfg_one;
  logic          wr_cfg_two;
  logic          wr_flt_en;
  logic          wr_evt;
  logic [63:0]   route_flat;
  assign wr_cfg_one = wr_i && (addr_i == ADDR_CFG_ONE);
  assign wr_cfg_two = wr_i && (addr_i == ADDR_CFG_TWO);
  assign wr_flt_en  = wr_i && (addr_i == ADDR_FLT_EN);
  // debug hook: software can inject fault events for bring-up
  assign wr_evt     = wr_i && (addr_i == ADDR_ERR_EVT);
  // bus-off holds tally at 255 visible
  assign err_word = {(tec_reg[8] ? 8'hFF : tec_reg[7:0]), rec_reg};
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_one_reg <= '0;
      cfg_two_reg <= '0;
      flt_en_reg  <= FLT_EN_RESET;
    end
    else
    begin
      if (wr_cfg_one)
        cfg_one_reg <= wdata_i & CFG_ONE_MASK;
      if (wr_cfg_two)
        cfg_two_reg <= wdata_i & CFG_TWO_MASK;
      if (wr_flt_en)
        flt_en_reg <= wdata_i;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_route
      always_ff @(posedge mclk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          route_reg[g] <= '0;
        else if (wr_i && (addr_i == ADDR_ROUTE0 + AW'(g)))
          route_reg[g] <= wdata_i;
      end
      assign route_flat[16*g +: 16] = route_reg[g];
    end
  endgenerate
  always_comb
  begin
    rdata_next = '0;
    case (addr_i)
      ADDR_ERR_CNT: rdata_next = err_word;
      ADDR_CFG_ONE: rdata_next = cfg_one_reg;
      ADDR_CFG_TWO: rdata_next = cfg_two_reg;
      ADDR_FLT_EN:  rdata_next = flt_en_reg;
      default:
        if (addr_i >= ADDR_ROUTE0 && addr_i < ADDR_ROUTE0 + AW'(4))
          rdata_next = route_reg[2'(addr_i - ADDR_ROUTE0)];
    endcase
  end
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= '0;
    else
      rdata_o <= rd_i ? rdata_next : '0;
  end
  // ***************************************************************
  // filter routing
  // ***************************************************************
  logic [3:0] dest_sel;
  assign dest_sel = route_flat[4*hit_num_i +: 4];
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      route_valid_o <= 1'b0;
      route_buf_o   <= '0;
      route_fifo_o  <= 1'b0;
    end
    else
    begin
      // disabled filters never deliver
      route_valid_o <= hit_i && flt_en_reg[hit_num_i];
      route_buf_o   <= dest_sel;
      route_fifo_o  <= hit_i && flt_en_reg[hit_num_i] && (dest_sel == DEST_FIFO);
    end
  end
  // ***************************************************************
  // bit timing
  // ***************************************************************
  typedef enum logic [1:0] {
    ST_SYNC = 2'b00,
    ST_SEG1 = 2'b01,
    ST_SEG2 = 2'b10
  } seg_e;
  seg_e       seg_reg;
  seg_e       seg_next;
  logic [6:0] pre_reg;
  logic [6:0] pre_lim;
  logic       quantum_tick;
  logic [4:0] quanta_reg;
  logic [4:0] seg1_len;
  logic [3:0] ph1_len;
  logic [3:0] ph2_len;
  logic [2:0] jump_len;
  logic [3:0] prs_len;
  logic       rx_prev_reg;
  logic       fall_edge;
  logic       late_edge;
  logic [2:0] smp_reg;
  logic       vote;
  assign pre_lim  = {cfg_one_reg[PRESC_LSB +: 6], 1'b1};
  // at or past the limit: a smaller prescaler written mid-quantum ends it at once
  assign quantum_tick = (pre_reg >= pre_lim);
  assign jump_len = {1'b0, cfg_one_reg[JUMP_LSB +: 2]} + 3'h1;
  assign prs_len  = {1'b0, cfg_two_reg[PRS_LSB +: 3]} + 4'h1;
  assign ph1_len  = {1'b0, cfg_two_reg[PH1_LSB +: 3]} + 4'h1;
  assign ph2_len  = cfg_two_reg[PH2TS_BIT] ? ({1'b0, cfg_two_reg[PH2_LSB +: 3]} + 4'h1)
                  : ((ph1_len > PROC_QUANTA) ? ph1_len : PROC_QUANTA);
  assign seg1_len = {1'b0, prs_len} + {1'b0, ph1_len};
  assign fall_edge = rx_prev_reg && !can_rx_i;
  // late edge only inside the jump window, never on the sample tick itself
  assign late_edge = fall_edge && seg_reg == ST_SEG1 && seg_next == ST_SEG1
                     && quanta_reg > 5'(prs_len) && quanta_reg <= 5'(prs_len) + 5'(jump_len);
  assign vote = cfg_two_reg[TRIPLE_BIT] ?
    ((smp_reg[0] & smp_reg[1]) | (smp_reg[0] & can_rx_i) | (smp_reg[1] & can_rx_i))
    : can_rx_i;
  // at or past the length: shorter segments written mid-bit end at once
  always_comb
  begin
    seg_next = seg_reg;
    case (seg_reg)
      ST_SYNC: seg_next = ST_SEG1;
      ST_SEG1: if (quanta_reg >= seg1_len) seg_next = ST_SEG2;
      ST_SEG2: if (quanta_reg >= {1'b0, ph2_len}) seg_next = ST_SYNC;
      default: seg_next = ST_SYNC;
    endcase
  end
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pre_reg <= '0;
      seg_reg <= ST_SYNC;
      quanta_reg <= 5'h1;
      rx_prev_reg <= 1'b1;
      smp_reg <= 3'h7;
      sample_o <= 1'b1;
      sample_pt_o <= 1'b0;
    end
    else
    begin
      rx_prev_reg <= can_rx_i;
      sample_pt_o <= 1'b0;
      pre_reg <= quantum_tick ? '0 : pre_reg + 7'h1;
      if (quantum_tick)
        smp_reg <= {smp_reg[1:0], can_rx_i};
      if (quantum_tick)
      begin
        if (seg_next != seg_reg)
          quanta_reg <= 5'h1;
        else
          quanta_reg <= quanta_reg + 5'h1;
        seg_reg <= seg_next;
        if (seg_reg == ST_SEG1 && seg_next == ST_SEG2)
        begin
          sample_o <= vote;
          sample_pt_o <= 1'b1;
        end
        // resync: late edge stretches phase one by at most jump width plus one quantum
        if (late_edge)
          quanta_reg <= 5'(prs_len);
      end
    end
  end
  // ***************************************************************
  // wake-up line filter
  // ***************************************************************
  logic [3:0] filt_reg;
  assign wake_o = cfg_two_reg[WAK_BIT] ? (filt_reg == 4'h0) : !can_rx_i;
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      filt_reg <= 4'hF;
    else
      filt_reg <= {filt_reg[2:0], can_rx_i};
  end
  // ***************************************************************
  // fault confinement tallies
  // ***************************************************************
  // event word: bit0 tx error, bit1 rx error, bit2 tx ok, bit3 rx ok
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tec_reg <= '0;
      rec_reg <= '0;
    end
    else if (wr_evt)
    begin
      if (wdata_i[0] && !tec_reg[8])
        tec_reg <= (tec_reg + 9'(TX_ERR_INC) >= TEC_BUSOFF) ? TEC_BUSOFF
                 : tec_reg + 9'(TX_ERR_INC);
      else if (wdata_i[2] && tec_reg != '0 && !tec_reg[8])
        tec_reg <= tec_reg - 9'h1;
      if (wdata_i[1] && rec_reg != 8'hFF)
        rec_reg <= rec_reg + RX_ERR_INC;
      else if (wdata_i[3] && rec_reg > RX_HALF)
        rec_reg <= RX_RESTART;
      else if (wdata_i[3] && rec_reg != '0)
        rec_reg <= rec_reg - 8'h1;
    end
  end
  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_err_ro;
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_i && addr_i == ADDR_ERR_CNT && !wr_evt |=> $stable(rec_reg) && $stable(tec_reg);
  endproperty
  a_err_ro: assert property (p_err_ro) else $error("error tally changed by write");
  property p_rd_lat;
    @(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == ADDR_FLT_EN |=> rdata_o == $past(flt_en_reg);
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("enable readback wrong");
  property p_tq;
    @(posedge mclk_i) disable iff (!rst_n_i)
    quantum_tick && $stable(cfg_one_reg) |=> !quantum_tick [*1] ##0 pre_reg == 7'h0;
  endproperty
  a_tq: assert property (p_tq) else $error("quantum divider wrong");
  property p_ph2;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !cfg_two_reg[PH2TS_BIT] |-> ph2_len >= ph1_len && ph2_len >= PROC_QUANTA;
  endproperty
  a_ph2: assert property (p_ph2) else $error("phase two source wrong");
  property p_fifo;
    @(posedge mclk_i) disable iff (!rst_n_i)
    route_fifo_o |-> route_valid_o && route_buf_o == DEST_FIFO;
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo routing wrong");
  property p_dis;
    @(posedge mclk_i) disable iff (!rst_n_i)
    hit_i && !flt_en_reg[hit_num_i] |=> !route_valid_o;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled filter routed");
  property p_wake;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !cfg_two_reg[WAK_BIT] |-> wake_o == !can_rx_i;
  endproperty
  a_wake: assert property (p_wake) else $error("filter bypass wrong");
  property p_smp;
    @(posedge mclk_i) disable iff (!rst_n_i)
    sample_pt_o |-> $past(seg_reg) == ST_SEG1;
  endproperty
  a_smp: assert property (p_smp) else $error("sample point misplaced");
  c_fifo: cover property (@(posedge mclk_i) disable iff (!rst_n_i) route_fifo_o);
  c_smp: cover property (@(posedge mclk_i) disable iff (!rst_n_i) sample_pt_o);
  c_tec: cover property (@(posedge mclk_i) disable iff (!rst_n_i) tec_reg[7]);
endmodule

// ==== rtl/unused_placeholder_none.sv ====
`timescale 1ns/10ps

// ==== verif/can_node_model.sv ====
// Purpose: other node on the bus, drives dominant spans
// Assumes: one clock, span length in clocks
// Notes:   line is recessive whenever no span runs
`timescale 1ns/10ps
module can_node_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [15:0] len_i,
  output logic             can_rx_o
);
  logic [15:0] cnt_reg;
  // ********
  // bus drive
  // ********
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_reg <= 16'h0000;
    else if (start_i)
      cnt_reg <= len_i;
    else if (cnt_reg != 16'h0000)
      cnt_reg <= cnt_reg - 16'h0001;
  end
  // recessive idle so resync sees a clean falling edge
  assign can_rx_o = (cnt_reg == 16'h0000);
endmodule

// ==== verif/can_timing_core_test.sv ====
// Purpose: register, routing, timing and wake tests
// Assumes: 100 ns clock, index map of the package
// Notes:   timing judged by spacing of sample pulses
`timescale 1ns/10ps
module can_timing_core_test;
  import can_timing_pkg::*;
  logic mclk_i, rst_n_i, wr_i, rd_i, hit_i, go, can_rx_i;
  logic [AW-1:0] addr_i;
  logic [DW-1:0] wdata_i, rdata_o, d, len;
  logic [3:0] hit_num_i, route_buf_o;
  logic route_valid_o, route_fifo_o, sample_o, sample_pt_o, wake_o;
  int fails, num_checks, cyc;
  can_timing_core u_can_timing_core (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .can_rx_i(can_rx_i), .hit_num_i(hit_num_i),
    .hit_i(hit_i), .route_valid_o(route_valid_o), .route_buf_o(route_buf_o),
    .route_fifo_o(route_fifo_o), .sample_o(sample_o),
    .sample_pt_o(sample_pt_o), .wake_o(wake_o));
  can_node_model u_can_node_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .start_i(go), .len_i(len), .can_rx_o(can_rx_i));
  // ********
  // tasks
  // ********
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a);
    @(posedge mclk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    d = rdata_o;
  endtask
  task automatic hit(input logic [3:0] n);
    @(posedge mclk_i);
    hit_i <= 1'b1; hit_num_i <= n;
    @(posedge mclk_i);
    hit_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic wait_pt();
    int n;
    n = 0;
    @(negedge mclk_i);
    while (sample_pt_o !== 1'b1 && n < 3000)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 3000)
    begin
      fails++;
      $display("[FAIL] %0t no sample point", $time);
    end
  endtask
  task automatic dom(input logic [15:0] l);
    @(posedge mclk_i);
    go <= 1'b1; len <= l;
    @(posedge mclk_i);
    go <= 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ********
  // clock, timeout
  // ********
  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      give_verdict();
    end
  end
  // ********
  // tests
  // ********
  initial
  begin : seq
    logic [15:0] cf [5][3];
    realtime t0;
    cf = '{'{16'h0000, 16'h0191, 16}, '{16'h0001, 16'h0191, 32},
           '{16'h0001, 16'h0151, 36}, '{16'h00C0, 16'h0000, 10},
           '{16'h003F, 16'h0787, 2304}};
    {rst_n_i, wr_i, rd_i, hit_i, go} = 5'h00;
    {addr_i, wdata_i, len, hit_num_i} = '0;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(ADDR_ERR_CNT); chk16(d, 16'h0000);
    rd(ADDR_FLT_EN); chk16(d, FLT_EN_RESET);
    for (int i = 0; i < 4; i++)
    begin
      rd(ADDR_ROUTE0 + i[3:0]); chk16(d, 16'h0000);
    end
    wr(ADDR_CFG_ONE, 16'hFFFF); rd(ADDR_CFG_ONE); chk16(d, 16'h00FF);
    wr(ADDR_CFG_TWO, 16'hFFFF); rd(ADDR_CFG_TWO); chk16(d, 16'h47FF);
    wr(ADDR_ERR_CNT, 16'h1234); rd(ADDR_ERR_CNT); chk16(d, 16'h0000);
    rd(4'hF); chk16(d, 16'h0000);
    wr(ADDR_ERR_EVT, 16'h0001); rd(ADDR_ERR_CNT); chk16(d, 16'h0800);
    wr(ADDR_ERR_EVT, 16'h0002); rd(ADDR_ERR_CNT); chk16(d, 16'h0801);
    wr(ADDR_ERR_EVT, 16'h0004); rd(ADDR_ERR_CNT); chk16(d, 16'h0701);
    wr(ADDR_ERR_EVT, 16'h0008); rd(ADDR_ERR_CNT); chk16(d, 16'h0700);
    $display("registers done");
    wr(ADDR_FLT_EN, 16'hFF7F);
    for (int i = 0; i < 4; i++)
      wr(ADDR_ROUTE0 + i[3:0], 16'hFEDC - 16'h4444 * i[15:0]);
    for (int f = 0; f < 16; f++)
    begin
      logic [15:0] r;
      logic [3:0] e;
      r = 16'hFEDC - 16'h4444 * f[17:2];
      e = r[4 * f[1:0] +: 4];
      hit(f[3:0]);
      chk16(route_buf_o, e);
      chk16(route_valid_o, f != 7);
      chk16(route_fifo_o, (e == DEST_FIFO) && f != 7);
    end
    $display("routing done");
    for (int k = 0; k < 5; k++)
    begin
      wr(ADDR_CFG_ONE, cf[k][0]);
      wr(ADDR_CFG_TWO, cf[k][1]);
      wait_pt(); wait_pt();
      t0 = $realtime;
      wait_pt();
      chk16(16'(int'(($realtime - t0) / 100)), cf[k][2]);
    end
    $display("timing done");
    wr(ADDR_CFG_ONE, 16'h0000);
    wr(ADDR_CFG_TWO, 16'h0191);
    dom(16'd40); chk16(wake_o, 1'b1);
    repeat (45) @(negedge mclk_i);
    chk16(wake_o, 1'b0);
    wr(ADDR_CFG_TWO, 16'h4191);
    dom(16'd300); chk16(wake_o, 1'b0);
    repeat (150) @(negedge mclk_i);
    chk16(wake_o, 1'b1);
    wait_pt(); chk16(sample_o, 1'b0);
    wr(ADDR_CFG_ONE, 16'h0001);
    wr(ADDR_CFG_TWO, 16'h0151);
    repeat (200) @(negedge mclk_i);
    wait_pt();
    // one-clock dominant glitch lands on the next sample tick, 36 clocks on
    repeat (33) @(negedge mclk_i);
    dom(16'd1);
    wait_pt(); chk16(sample_o, 1'b1);
    $display("wake done");
    give_verdict();
  end
endmodule
